// ### verilog/phec_defines.svh
// register offsets, reset values and widths of the error counter bank
// assumes an 8-bit register port with a byte address
`ifndef PHEC_DEFINES_SVH
`define PHEC_DEFINES_SVH

`define PHEC_ADDR_W 8
`define PHEC_DATA_W 8
`define PHEC_CNT_W 16
`define PHEC_NUM_CNT 4

`define PHEC_OFF_FRM_HI 8'h2a
`define PHEC_OFF_FRM_LO 8'h2b
`define PHEC_OFF_FAR_HI 8'h2c
`define PHEC_OFF_FAR_LO 8'h2d
`define PHEC_OFF_SHE_HI 8'h2e
`define PHEC_OFF_SHE_LO 8'h2f
`define PHEC_OFF_MHE_HI 8'h30
`define PHEC_OFF_MHE_LO 8'h31
`define PHEC_OFF_MODE 8'h40

`define PHEC_MODE_ATM_BIT 0
`define PHEC_MODE_PLCP_BIT 1

`define PHEC_CNT_RST 16'h0000
`define PHEC_BYTE_RST 8'h00
`define PHEC_MODE_RST 2'h0

`endif

// ### verilog/phec_pkg.sv
// types shared by the error counter bank
// assumes phec_defines.svh for widths
`include "phec_defines.svh"

package phec_pkg;
    typedef enum logic [1:0] {
        PHEC_CNT_FRAMING,
        PHEC_CNT_FAR_BLOCK,
        PHEC_CNT_SINGLE_HDR,
        PHEC_CNT_MULTI_HDR
    } phec_cnt_sel_t;

    typedef enum logic [1:0] {
        PHEC_ACC_NONE,
        PHEC_ACC_HIGH,
        PHEC_ACC_LOW,
        PHEC_ACC_MODE
    } phec_acc_t;

    typedef struct packed {
        phec_acc_t acc;
        phec_cnt_sel_t sel;
    } phec_dec_t;
endpackage

// ### verilog/phec_event_counter.sv
// one 16-bit clear-on-read event counter with a read snapshot
// assumes inc_in and take_in are one-cycle pulses on ref_clk_in
`timescale 1ns/1ps
`include "phec_defines.svh"

module phec_event_counter
    import phec_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // control
    input wire logic inc_in,
    input wire logic take_in,
    // state
    output logic [`PHEC_CNT_W-1:0] count_out,
    output logic [`PHEC_CNT_W-1:0] snap_out
);
    logic [`PHEC_CNT_W-1:0] count_q;
    logic [`PHEC_CNT_W-1:0] snap_q;

    // take zeroes the live count while the event of the same cycle
    // lands in the fresh count, so nothing is lost
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            count_q <= `PHEC_CNT_RST;
        end else if (take_in) begin
            count_q <= {{(`PHEC_CNT_W-1){1'b0}}, inc_in};
        end else if (inc_in && count_q != {`PHEC_CNT_W{1'b1}}) begin
            count_q <= count_q + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            snap_q <= `PHEC_CNT_RST;
        end else if (take_in) begin
            snap_q <= count_q;
        end
    end

    assign count_out = count_q;
    assign snap_out = snap_q;
endmodule

// ### verilog/phec_addr_decode.sv
// address decoder for the counter bank and its mode register
// assumes byte addresses on the register port
`timescale 1ns/1ps
`include "phec_defines.svh"

module phec_addr_decode
    import phec_pkg::*;
(
    // address
    input wire logic [`PHEC_ADDR_W-1:0] addr_in,
    // decoded access
    output phec_dec_t dec_out
);
    function automatic phec_dec_t decode(input logic [7:0] a);
        phec_dec_t d;
        d.acc = PHEC_ACC_NONE;
        d.sel = PHEC_CNT_FRAMING;
        case (a)
            `PHEC_OFF_FRM_HI: d = '{PHEC_ACC_HIGH, PHEC_CNT_FRAMING};
            `PHEC_OFF_FRM_LO: d = '{PHEC_ACC_LOW, PHEC_CNT_FRAMING};
            `PHEC_OFF_FAR_HI: d = '{PHEC_ACC_HIGH, PHEC_CNT_FAR_BLOCK};
            `PHEC_OFF_FAR_LO: d = '{PHEC_ACC_LOW, PHEC_CNT_FAR_BLOCK};
            `PHEC_OFF_SHE_HI: d = '{PHEC_ACC_HIGH, PHEC_CNT_SINGLE_HDR};
            `PHEC_OFF_SHE_LO: d = '{PHEC_ACC_LOW, PHEC_CNT_SINGLE_HDR};
            `PHEC_OFF_MHE_HI: d = '{PHEC_ACC_HIGH, PHEC_CNT_MULTI_HDR};
            `PHEC_OFF_MHE_LO: d = '{PHEC_ACC_LOW, PHEC_CNT_MULTI_HDR};
            `PHEC_OFF_MODE: d.acc = PHEC_ACC_MODE;
            default: d.acc = PHEC_ACC_NONE;
        endcase
        return d;
    endfunction

    assign dec_out = decode(addr_in);
endmodule

// ### verilog/plcp_hec_error_counters.sv
// Function
// - count framing byte errors, sixteen bits
// - count far-end block error events, sixteen bits
// - first two count only in cell+mapping mode
// - count single-bit header errors, sixteen bits
// - count multi-bit header errors separately
// - header counts only in cell mode
// - reading a counter clears it
// - each counter read as high, low byte
// - counters are zero after reset
//
// top of the error counter bank: register port, mode and four counters
// assumes event inputs are one-cycle pulses synchronous to ref_clk_in
`timescale 1ns/1ps
`include "phec_defines.svh"

module plcp_hec_error_counters
    import phec_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [`PHEC_ADDR_W-1:0] addr_in,
    input wire logic [`PHEC_DATA_W-1:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [`PHEC_DATA_W-1:0] rd_data_out,
    // error detector pulses
    input wire logic framing_err_in,
    input wire logic far_block_err_in,
    input wire logic single_bit_header_error_in,
    input wire logic multi_bit_header_error_in,
    // mode state
    output logic atm_mode_out,
    output logic plcp_mode_out
);
    phec_dec_t dec;
    logic [1:0] mode_q;
    logic [`PHEC_DATA_W-1:0] rd_data_q;
    logic [`PHEC_NUM_CNT-1:0] inc;
    logic [`PHEC_NUM_CNT-1:0] take;
    logic [`PHEC_NUM_CNT-1:0] fresh_q;
    logic [`PHEC_CNT_W-1:0] count [`PHEC_NUM_CNT];
    logic [`PHEC_CNT_W-1:0] snap [`PHEC_NUM_CNT];
    logic atm_on;
    logic plcp_on;
    logic cnt_rd;

    phec_addr_decode phec_addr_decode_i (
        .addr_in(addr_in),
        .dec_out(dec)
    );

    assign atm_on = mode_q[`PHEC_MODE_ATM_BIT];
    assign plcp_on = mode_q[`PHEC_MODE_PLCP_BIT];
    assign cnt_rd = rd_in && (dec.acc == PHEC_ACC_HIGH ||
                              dec.acc == PHEC_ACC_LOW);

    // counting enables follow the operating mode
    always_comb begin
        inc[PHEC_CNT_FRAMING] = framing_err_in && atm_on && plcp_on;
        inc[PHEC_CNT_FAR_BLOCK] = far_block_err_in && atm_on && plcp_on;
        inc[PHEC_CNT_SINGLE_HDR] = single_bit_header_error_in && atm_on;
        inc[PHEC_CNT_MULTI_HDR] = multi_bit_header_error_in && atm_on;
    end

    // the first byte read of a pair takes the snapshot; the partner byte
    // then reads the same snapshot, so high and low always agree
    always_comb begin
        take = '0;
        if (cnt_rd && !fresh_q[dec.sel]) begin
            take[dec.sel] = 1'b1;
        end
    end

    // a pair is open after its first byte read until the next read of either byte of that counter
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            fresh_q <= '0;
        end else if (cnt_rd) begin
            fresh_q[dec.sel] <= !fresh_q[dec.sel];
        end
    end

    for (genvar i = 0; i < `PHEC_NUM_CNT; i++) begin : g_cnt
        phec_event_counter phec_event_counter_i (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .inc_in(inc[i]),
            .take_in(take[i]),
            .count_out(count[i]),
            .snap_out(snap[i])
        );
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            mode_q <= `PHEC_MODE_RST;
        end else if (wr_in && dec.acc == PHEC_ACC_MODE) begin
            mode_q <= wr_data_in[1:0];
        end
    end

    // read data: a take reads the live count, a partner byte the snapshot
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rd_data_q <= `PHEC_BYTE_RST;
        end else if (rd_in) begin
            case (dec.acc)
                PHEC_ACC_HIGH: begin
                    rd_data_q <= fresh_q[dec.sel] ?
                        snap[dec.sel][15:8] : count[dec.sel][15:8];
                end
                PHEC_ACC_LOW: begin
                    rd_data_q <= fresh_q[dec.sel] ?
                        snap[dec.sel][7:0] : count[dec.sel][7:0];
                end
                PHEC_ACC_MODE: rd_data_q <= {6'h00, mode_q};
                default: rd_data_q <= `PHEC_BYTE_RST;
            endcase
        end else begin
            rd_data_q <= `PHEC_BYTE_RST;
        end
    end

    assign rd_data_out = rd_data_q;
    assign atm_mode_out = mode_q[`PHEC_MODE_ATM_BIT];
    assign plcp_mode_out = mode_q[`PHEC_MODE_PLCP_BIT];
endmodule

// ### sim/phec_properties.sv
// port checker for the error counter bank
// assumes it is bound to plcp_hec_error_counters
`timescale 1ns/1ps
module phec_checker (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rd_data_out,
    // mode state
    input wire logic atm_mode_out,
    input wire logic plcp_mode_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic hit;
    logic [1:0] md;
    assign hit = addr_in inside {[8'h2a:8'h31], 8'h40};
    assign md = {plcp_mode_out, atm_mode_out};
    idle_zero_a: assert property (!$past(rd_in) |-> rd_data_out == 8'h00)
        else $error("read data without a read");
    unmapped_a: assert property (rd_in && !hit |=> rd_data_out == 8'h00)
        else $error("unmapped read not zero");
    reset_clear_a: assert property ($past(rst_in) |-> md == 2'h0 &&
        rd_data_out == 8'h00) else $error("state not clear after reset");
    atm_set_a: assert property (wr_in && addr_in == 8'h40 |=>
        atm_mode_out == $past(wr_data_in[0])) else $error("cell mode bit");
    plcp_set_a: assert property (wr_in && addr_in == 8'h40 |=>
        plcp_mode_out == $past(wr_data_in[1])) else $error("mapping bit");
    mode_hold_a: assert property (!wr_in |=> $stable(md))
        else $error("mode moved without write");
    cnt_write_a: assert property (wr_in && addr_in != 8'h40 |=> $stable(md))
        else $error("counter write changed mode");
    write_quiet_a: assert property (wr_in |=> rd_data_out == 8'h00)
        else $error("read data after a write");
    cover property (rd_in && addr_in == 8'h2a);
    cover property (wr_in && addr_in == 8'h40 && wr_data_in == 8'h03);
    cover property (rd_in && addr_in == 8'h31);
endmodule

bind plcp_hec_error_counters phec_checker phec_checker_i (.ref_clk_in,
    .rst_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out,
    .atm_mode_out, .plcp_mode_out);

// ### sim/plcp_hec_error_counters_test.sv
// self-checking bench for the error counter bank
// assumes read data stand only in the cycle after rd_in
`timescale 1ns/1ps
module plcp_hec_error_counters_test;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wr_data_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [3:0] ev_q = 4'h0;
    logic [7:0] rd_data_out;
    logic atm_mode_out;
    logic plcp_mode_out;
    logic [7:0] d;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    plcp_hec_error_counters plcp_hec_error_counters_i (.ref_clk_in, .rst_in,
        .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out,
        .framing_err_in(ev_q[0]), .far_block_err_in(ev_q[1]),
        .single_bit_header_error_in(ev_q[2]),
        .multi_bit_header_error_in(ev_q[3]), .atm_mode_out, .plcp_mode_out);
    always #20 ref_clk_in = ~ref_clk_in;
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        wr_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= v;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe; taking them at
    // the following edge sees the settled value, not the launch race
    task automatic rd(input logic [7:0] a);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        @(posedge ref_clk_in);
        d = rd_data_out;
    endtask
    task automatic rp(input logic [7:0] a, input logic [15:0] e);
        rd(a);
        chk(d, e[15:8]);
        rd(a + 8'h01);
        chk(d, e[7:0]);
    endtask
    // pulses are spaced by an idle cycle, one event each
    task automatic ev(input int i, input int n);
        repeat (n) begin
            ev_q <= 4'h1 << i;
            @(posedge ref_clk_in);
            ev_q <= 4'h0;
            @(posedge ref_clk_in);
        end
    endtask
    task automatic t_start();
        for (int a = 8'h2a; a < 8'h32; a += 2)
            rp(8'(a), 16'h0000);
        rd(8'h50);
        chk(d, 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_modes();
        wr(8'h40, 8'h02);
        @(posedge ref_clk_in);
        chk({plcp_mode_out, atm_mode_out}, 16'h0002);
        for (int i = 0; i < 4; i++) ev(i, i + 2);
        for (int a = 8'h2a; a < 8'h32; a += 2)
            rp(8'(a), 16'h0000);
        wr(8'h40, 8'h01);
        @(posedge ref_clk_in);
        chk({plcp_mode_out, atm_mode_out}, 16'h0001);
        for (int i = 0; i < 4; i++) ev(i, i + 2);
        wr(8'h2e, 8'hff);
        rp(8'h2a, 16'h0000);
        rp(8'h2c, 16'h0000);
        rp(8'h2e, 16'h0004);
        rp(8'h30, 16'h0005);
        $display("mode test done");
    endtask
    task automatic t_count();
        wr(8'h40, 8'h03);
        rd(8'h40);
        chk(d, 16'h0003);
        ev(0, 300);
        ev(1, 257);
        rp(8'h2a, 16'h012c);
        rp(8'h2c, 16'h0101);
        rp(8'h2a, 16'h0000);
        $display("count test done");
    endtask
    // the event lands in the same cycle as the first byte read
    task automatic t_snap();
        ev(3, 258);
        rd_in <= 1'b1;
        addr_in <= 8'h30;
        ev_q <= 4'h8;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        ev_q <= 4'h0;
        @(posedge ref_clk_in);
        chk(rd_data_out, 16'h0001);
        rd(8'h31);
        chk(d, 16'h0002);
        rp(8'h30, 16'h0001);
        $display("snapshot test done");
    endtask
    // reset in mid-run must drop counts and mode gathered so far
    task automatic t_reset();
        ev(2, 3);
        rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        chk({plcp_mode_out, atm_mode_out}, 16'h0000);
        rp(8'h2e, 16'h0000);
        $display("mid-run reset test done");
    endtask
    initial begin
        repeat (5) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        t_start();
        t_modes();
        t_count();
        t_snap();
        t_reset();
        end_of_test();
    end
endmodule
